// >>> bench/ccs_clock_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module ccs_clock_ctrl_monitor #(
    parameter int LONG_WDT_CYCLES = ccs_pkg::WDT_CYCLES_64MS
) (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RESET,
    input wire logic [1:0] I_CLOCK_SOURCE_SELECT,
    input wire logic [1:0] I_STARTUP_DELAY_SELECT,
    input wire logic       I_DIVIDE_BY_EIGHT_OPTION,
    input wire logic       I_WDT_OSC_CLK,
    input wire logic       I_EXT_INT,
    input wire logic       I_TRIM_WR,
    input wire logic [7:0] I_TRIM_WDATA,
    input wire logic       I_SLEEP_REQ,
    input wire logic [1:0] I_SLEEP_MODE,
    input wire logic [7:0] O_OSCILLATOR_TRIM,
    input wire logic       O_RC_FAST,
    input wire logic       O_RC_ENABLE,
    input wire logic       O_LOWRATE_ENABLE,
    input wire logic [3:0] O_PRESCALE_SELECT,
    input wire logic       O_WDT_TICK,
    input wire logic       O_EXT_INT_SEEN,
    input wire logic       O_RUN,
    input wire logic       O_CPU_CLK_EN,
    input wire logic       O_IO_CLK_EN,
    input wire logic       O_FLASH_CLK_EN,
    input wire logic       O_ADC_CLK_EN
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);

    // ----------------------------------------
    // watchdog ticks seen before first run
    // ----------------------------------------
    logic [15:0] wdt_n_ff;
    logic        booted_ff;
    logic [15:0] wdt_tgt;

    assign wdt_tgt = (I_STARTUP_DELAY_SELECT == ccs_pkg::SUT_14CK) ? 16'h0 :
                     (I_STARTUP_DELAY_SELECT == ccs_pkg::SUT_14CK_4MS) ? 16'h0200 :
                     16'(LONG_WDT_CYCLES);

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            wdt_n_ff  <= 16'h0;
            booted_ff <= 1'h0;
        end else begin
            if (O_WDT_TICK && !booted_ff) begin
                wdt_n_ff <= wdt_n_ff + 16'h1;
            end
            if (O_RUN) begin
                booted_ff <= 1'h1;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_trim_write;
        I_TRIM_WR && O_RUN |-> ##2 O_OSCILLATOR_TRIM == {1'h0, $past(I_TRIM_WDATA[6:0], 2)};
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("trim write not reflected");
    property p_rc_fast;
        O_RUN |-> O_RC_FAST == (I_CLOCK_SOURCE_SELECT == ccs_pkg::SRC_RC_9M6);
    endproperty
    a_rc_fast: assert property (p_rc_fast)
        else $error("rc rate wrong");
    property p_rc_en;
        O_RUN |-> O_RC_ENABLE == (I_CLOCK_SOURCE_SELECT inside {2'h1, 2'h2});
    endproperty
    a_rc_en: assert property (p_rc_en)
        else $error("rc enable wrong");
    property p_lowrate;
        O_RUN |-> O_LOWRATE_ENABLE == (I_CLOCK_SOURCE_SELECT == ccs_pkg::SRC_LOWRATE);
    endproperty
    a_lowrate: assert property (p_lowrate)
        else $error("low-rate enable wrong");
    property p_prescale;
        O_RUN |-> O_PRESCALE_SELECT == (I_DIVIDE_BY_EIGHT_OPTION ? 4'h0 : 4'h3);
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("prescale reset value wrong");
    property p_gates_together;
        $rose(O_CPU_CLK_EN) |-> O_RUN && O_IO_CLK_EN && O_FLASH_CLK_EN && O_ADC_CLK_EN;
    endproperty
    a_gates_together: assert property (p_gates_together)
        else $error("gates not opened together");
    property p_pd_gates;
        O_RUN && I_SLEEP_REQ && I_SLEEP_MODE[1] |-> ##2 !O_RUN && !(O_CPU_CLK_EN
            || O_IO_CLK_EN || O_FLASH_CLK_EN || O_ADC_CLK_EN);
    endproperty
    a_pd_gates: assert property (p_pd_gates)
        else $error("power-down left a gate open");
    property p_ext_int;
        I_EXT_INT [*4] |-> O_EXT_INT_SEEN;
    endproperty
    a_ext_int: assert property (p_ext_int)
        else $error("external interrupt not seen");
    property p_wdt_tick;
        $rose(I_WDT_OSC_CLK) |-> ##[1:4] O_WDT_TICK ##1 !O_WDT_TICK;
    endproperty
    a_wdt_tick: assert property (p_wdt_tick)
        else $error("watchdog tick missing");
    property p_boot_wdt;
        $rose(O_RUN) && !booted_ff |-> wdt_n_ff >= wdt_tgt && wdt_n_ff <= wdt_tgt + 16'h8;
    endproperty
    a_boot_wdt: assert property (p_boot_wdt)
        else $error("reset delay watchdog count wrong");
endmodule

bind ccs_clock_ctrl ccs_clock_ctrl_monitor #(.LONG_WDT_CYCLES(LONG_WDT_CYCLES)) i_mon (.*);

`default_nettype wire

// >>> bench/ccs_osc_model.sv
`timescale 1ns/1ns
`default_nettype none

module ccs_osc_model (
    input  wire logic [7:0] i_trim,
    input  wire logic       i_rc_en,
    input  wire logic       i_rc_fast,
    input  wire logic       i_lr_en,
    output var  logic       o_ext_clk,
    output var  logic       o_rc_clk,
    output var  logic       o_lr_clk,
    output var  logic       o_wdt_clk
);
    int half;

    // ----------------------------------------
    // oscillators, disabled ones stand low
    // ----------------------------------------
    initial begin
        o_ext_clk = 1'h0;
        forever #100 o_ext_clk = ~o_ext_clk;
    end

    initial begin
        o_rc_clk = 1'h0;
        forever begin
            if (i_rc_en) begin
                half = (i_rc_fast ? 120 : 240) * 192 / (128 + int'(i_trim[6:0]));
                #(half > 40 ? half : 90) o_rc_clk = ~o_rc_clk;
            end else begin
                o_rc_clk = 1'h0;
                @(i_rc_en);
            end
        end
    end

    initial begin
        o_lr_clk = 1'h0;
        forever #300 o_lr_clk = i_lr_en & ~o_lr_clk;
    end

    initial begin
        o_wdt_clk = 1'h0;
        forever #1000 o_wdt_clk = ~o_wdt_clk;
    end
endmodule

`default_nettype wire

// >>> bench/clock_source_and_startup_control_tb.sv
`timescale 1ns/1ns
`default_nettype none

module clock_source_and_startup_control_tb;
    localparam int LONG  = 16;
    localparam int LIMIT = 60000;

    logic        clk = 1'h0, rst = 1'h1, div8 = 1'h0, ext_int = 1'h0, wake = 1'h0;
    logic        trim_wr = 1'h0, slp_req = 1'h0, src_p = 1'h0, wdt_p = 1'h0;
    logic [1:0]  src = 2'h2, startup_delay_select = 2'h2, slp_md = 2'h0;
    logic [6:0]  cal = 7'h00;
    logic [7:0]  trim_wd = 8'h00, trim;
    logic [3:0]  ps;
    logic        ext_clk, rc_clk, lr_clk, wdt_clk, sel_clk;
    logic        rc_fast, rc_en, lr_en, run, int_seen, tick;
    wire  [3:0]  gates;
    logic [31:0] seed = 32'h5D35E91C;
    int          error_cnt = 0, n_checks = 0, cyc = 0, src_n = 0, wdt_n = 0, tick_n = 0, n, tgt;
    int          trim_q[$];

    assign sel_clk = src[0] ? (src[1] ? lr_clk : rc_clk) : (src[1] ? rc_clk : ext_clk);

    ccs_clock_ctrl #(.LONG_WDT_CYCLES(LONG)) i_ccs_clock_ctrl (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_CLOCK_SOURCE_SELECT(src),
        .I_STARTUP_DELAY_SELECT(startup_delay_select), .I_DIVIDE_BY_EIGHT_OPTION(div8),
        .I_EXTERNAL_CLOCK_INPUT(ext_clk), .I_RC_OSC_CLK(rc_clk), .I_LOWRATE_OSC_CLK(lr_clk),
        .I_WDT_OSC_CLK(wdt_clk), .I_EXT_INT(ext_int), .I_FACTORY_CAL(cal),
        .I_TRIM_WR(trim_wr), .I_TRIM_WDATA(trim_wd), .I_SLEEP_REQ(slp_req),
        .I_SLEEP_MODE(slp_md), .I_WAKE(wake), .O_OSCILLATOR_TRIM(trim), .O_RC_FAST(rc_fast),
        .O_RC_ENABLE(rc_en), .O_LOWRATE_ENABLE(lr_en), .O_PRESCALE_SELECT(ps),
        .O_SYS_TICK(tick), .O_WDT_TICK(), .O_EXT_INT_SEEN(int_seen), .O_RUN(run),
        .O_CPU_CLK_EN(gates[3]), .O_IO_CLK_EN(gates[2]), .O_FLASH_CLK_EN(gates[1]),
        .O_ADC_CLK_EN(gates[0]));

    ccs_osc_model i_ccs_osc_model (.i_trim(trim), .i_rc_en(rc_en), .i_rc_fast(rc_fast),
        .i_lr_en(lr_en), .o_ext_clk(ext_clk), .o_rc_clk(rc_clk), .o_lr_clk(lr_clk),
        .o_wdt_clk(wdt_clk));

    // ----------------------------------------
    // clock, edge counters, timeout
    // ----------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        src_p <= sel_clk;
        wdt_p <= wdt_clk;
        src_n <= rst ? 0 : src_n + int'(sel_clk && !src_p);
        wdt_n <= rst ? 0 : wdt_n + int'(wdt_clk && !wdt_p);
        tick_n <= rst ? 0 : tick_n + int'(tick);
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            give_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [4:0] cfg);
        @(posedge clk);
        seed = lfsr(seed);
        rst <= 1'h1;
        {src, startup_delay_select, div8} <= cfg;
        cal <= seed[6:0];
        repeat (12) @(posedge clk);
        rst <= 1'h0;
    endtask

    // source edges from the moment t watchdog edges were reached until run
    task automatic wait_run(input int t, output int e);
        int s0;
        s0 = -1;
        for (int k = 0; k < 40000 && run !== 1'h1; k++) begin
            if (s0 < 0 && wdt_n >= t) s0 = src_n;
            @(posedge clk);
            #1;
        end
        e = src_n - s0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [4:0] cs [4] = '{5'h14, 5'h01, 5'h0A, 5'h1F}; // shipped fuses first
        logic [3:0] gm [3] = '{4'h5, 4'h1, 4'h0};
        logic [6:0] tv;
        for (int c = 0; c < 4; c++) begin
            do_reset(cs[c]);
            tgt = (startup_delay_select == 2'h0) ? 0 : (startup_delay_select == 2'h1) ? 512 : LONG;
            wait_run(tgt, n);
            check("start edges", 16'(n >= 14 && n <= 18), 16'h1);
            check("start wdt", 16'(wdt_n >= tgt), 16'h1);
            check("rc fast", 16'(rc_fast), 16'(src == 2'h2));
            check("rc enable", 16'(rc_en), 16'(src == 2'h1 || src == 2'h2));
            check("low-rate", 16'(lr_en), 16'(src == 2'h3));
            check("prescale", 16'(ps), div8 ? 16'h0 : 16'h3);
            check("ticks", 16'((tick_n - (src_n >> ps)) inside {[-2:2]}), 16'h1);
            check("trim load", 16'(trim), 16'(cal));
            check("gates", 16'(gates), 16'hF);
            $display("start-up test %0d done", c);
        end
        tv = cal;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            tv = tv ^ seed[4:0]; // step below 0x20
            trim_wr <= (i < 4);
            trim_wd <= {seed[31], tv};
            if (i < 4) trim_q.push_back(int'(tv));
            #1;
            if (i >= 2 && i < 6) check("trim write", 16'(trim), 16'(trim_q.pop_front()));
        end
        $display("trim test done");
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            slp_req <= 1'h1;
            slp_md <= 2'(m + (m / 2) * int'(seed[0])); // 11 also power-down
            @(posedge clk);
            slp_req <= 1'h0;
            repeat (2) @(posedge clk);
            #1;
            check("sleep gates", 16'({run, gates}), 16'(gm[m]));
            @(posedge clk);
            if (m == 1) ext_int <= 1'h1;
            else wake <= 1'h1;
            @(posedge clk);
            wake <= 1'h0;
            wait_run(0, n);
            if (m == 1) check("ext int", 16'(int_seen), 16'h1);
            if (m == 2) check("wake edges", 16'(n >= 6 && n <= 9), 16'h1);
            check("wake gates", 16'(gates), 16'hF);
            ext_int <= 1'h0;
            repeat (8) @(posedge clk);
            $display("sleep test %0d done", m);
        end
        give_verdict();
    end
endmodule

`default_nettype wire

// >>> core/ccs_clock_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - source 00 takes external clock input
// - source 10 RC 9.6 MHz, 01 RC 4.8 MHz
// - source 11 takes low-rate oscillator
// - fuse bit 1 unprogrammed, 0 programmed
// - power-down wake waits 6 source cycles
// - reset timeout 512 or 8192 watchdog cycles
// - startup select adds 14 CK plus timeout
// - shipped fuses give RC, longest delay, div8
// - every reset loads factory calibration into trim
// - trim bit 7 reads zero, 6..0 value
// - trim zero slowest, 7F fastest, monotonic
// - trim range 50-100, 75-150, 100-200 percent
// - watchdog oscillator always times watchdog, reset
// - core and flash clocks gate together, io and adc separately
// - external interrupt seen with io clock halted
// - divide-by-eight fuse sets prescale reset value
module ccs_clock_ctrl #(
    parameter int LONG_WDT_CYCLES = ccs_pkg::WDT_CYCLES_64MS
) (
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RESET,
    input  wire logic [1:0] I_CLOCK_SOURCE_SELECT,
    input  wire logic [1:0] I_STARTUP_DELAY_SELECT,
    input  wire logic       I_DIVIDE_BY_EIGHT_OPTION,
    input  wire logic       I_EXTERNAL_CLOCK_INPUT,
    input  wire logic       I_RC_OSC_CLK,
    input  wire logic       I_LOWRATE_OSC_CLK,
    input  wire logic       I_WDT_OSC_CLK,
    input  wire logic       I_EXT_INT,
    input  wire logic [6:0] I_FACTORY_CAL,
    input  wire logic       I_TRIM_WR,
    input  wire logic [7:0] I_TRIM_WDATA,
    input  wire logic       I_SLEEP_REQ,
    input  wire logic [1:0] I_SLEEP_MODE,
    input  wire logic       I_WAKE,
    output var  logic [7:0] O_OSCILLATOR_TRIM,
    output var  logic       O_RC_FAST,
    output var  logic       O_RC_ENABLE,
    output var  logic       O_LOWRATE_ENABLE,
    output var  logic [3:0] O_PRESCALE_SELECT,
    output var  logic       O_SYS_TICK,
    output var  logic       O_WDT_TICK,
    output var  logic       O_EXT_INT_SEEN,
    output var  logic       O_RUN,
    output var  logic       O_CPU_CLK_EN,
    output var  logic       O_IO_CLK_EN,
    output var  logic       O_FLASH_CLK_EN,
    output var  logic       O_ADC_CLK_EN
);

    localparam logic [13:0] LONG_WDT = 14'(LONG_WDT_CYCLES);

    ccs_pkg::ccs_state_t state_ff;
    ccs_pkg::ccs_state_t nxt_state;

    logic [ccs_pkg::SYNC_W-1:0] sync_in;
    logic [ccs_pkg::SYNC_W-1:0] sync_out;
    logic [3:0]  prev_ff;
    logic [1:0]  settle_ff;
    logic [1:0]  src_sel_ff;
    logic [1:0]  sut_sel_ff;
    logic        div8_ff;
    logic [6:0]  trim_ff;
    logic [3:0]  prescale_ff;
    logic [13:0] cnt_ff;
    logic [13:0] nxt_cnt;
    logic [7:0]  div_cnt_ff;
    logic [7:0]  div_mask;
    logic [1:0]  mode_ff;
    logic        src_edge;
    logic        wdt_edge;
    logic        wake_evt;
    logic [13:0] wdt_target;
    logic        run_gate;

    // ------------------------------------------------------------
    // synchronise pins and fuses
    // ------------------------------------------------------------
    assign sync_in = {I_DIVIDE_BY_EIGHT_OPTION, I_STARTUP_DELAY_SELECT,
                      I_CLOCK_SOURCE_SELECT, I_EXT_INT, I_WDT_OSC_CLK,
                      I_LOWRATE_OSC_CLK, I_RC_OSC_CLK, I_EXTERNAL_CLOCK_INPUT};

    ccs_sync #(
        .WIDTH (ccs_pkg::SYNC_W)
    ) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_async (sync_in),
        .o_sync  (sync_out)
    );

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= sync_out[ccs_pkg::SY_WDT_CLK:ccs_pkg::SY_EXT_CLK];
        end
    end

    // ------------------------------------------------------------
    // source select and edge detection
    // ------------------------------------------------------------
    always_comb begin
        unique case (src_sel_ff)
            ccs_pkg::SRC_EXT_CLOCK: begin
                src_edge = sync_out[ccs_pkg::SY_EXT_CLK] & ~prev_ff[ccs_pkg::SY_EXT_CLK];
            end
            ccs_pkg::SRC_RC_4M8, ccs_pkg::SRC_RC_9M6: begin
                src_edge = sync_out[ccs_pkg::SY_RC_CLK] & ~prev_ff[ccs_pkg::SY_RC_CLK];
            end
            ccs_pkg::SRC_LOWRATE: begin
                src_edge = sync_out[ccs_pkg::SY_LR_CLK] & ~prev_ff[ccs_pkg::SY_LR_CLK];
            end
        endcase
    end

    assign wdt_edge = sync_out[ccs_pkg::SY_WDT_CLK] & ~prev_ff[ccs_pkg::SY_WDT_CLK];
    assign wake_evt = I_WAKE | sync_out[ccs_pkg::SY_EXT_INT];

    always_comb begin
        unique case (sut_sel_ff)
            ccs_pkg::SUT_14CK:     wdt_target = '0;
            ccs_pkg::SUT_14CK_4MS: wdt_target = ccs_pkg::WDT_CYCLES_4MS;
            default:               wdt_target = LONG_WDT;
        endcase
    end

    // ------------------------------------------------------------
    // fuse capture and trim register
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            settle_ff <= '0;
        end else if (state_ff == ccs_pkg::ST_LOAD) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            src_sel_ff <= ccs_pkg::SRC_RC_9M6;
            sut_sel_ff <= ccs_pkg::SUT_14CK_64MS;
            div8_ff    <= ccs_pkg::FUSE_PROGRAMMED;
        end else if (state_ff == ccs_pkg::ST_LOAD) begin
            src_sel_ff <= sync_out[ccs_pkg::SY_SRC_HI:ccs_pkg::SY_SRC_LO];
            sut_sel_ff <= sync_out[ccs_pkg::SY_SUT_HI:ccs_pkg::SY_SUT_LO];
            div8_ff    <= sync_out[ccs_pkg::SY_DIV8];
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            trim_ff <= ccs_pkg::TRIM_RST;
        end else if (state_ff == ccs_pkg::ST_LOAD) begin
            trim_ff <= I_FACTORY_CAL;
        end else if (I_TRIM_WR) begin
            trim_ff <= I_TRIM_WDATA[6:0];
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            prescale_ff <= ccs_pkg::PRESCALE_RST_DIV8;
        end else if (state_ff == ccs_pkg::ST_LOAD) begin
            if (sync_out[ccs_pkg::SY_DIV8] == ccs_pkg::FUSE_PROGRAMMED) begin
                prescale_ff <= ccs_pkg::PRESCALE_RST_DIV8;
            end else begin
                prescale_ff <= ccs_pkg::PRESCALE_RST_DIV1;
            end
        end
    end

    // ------------------------------------------------------------
    // start-up sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            ccs_pkg::ST_LOAD: begin
                nxt_cnt = '0;
                if (settle_ff == ccs_pkg::SYNC_SETTLE_CYCLES) begin
                    nxt_state = ccs_pkg::ST_RESET_WDT;
                end
            end
            ccs_pkg::ST_RESET_WDT: begin
                if (cnt_ff >= wdt_target) begin
                    nxt_state = ccs_pkg::ST_RESET_CK;
                    nxt_cnt   = '0;
                end else if (wdt_edge) begin
                    nxt_cnt = cnt_ff + 14'h1;
                end
            end
            ccs_pkg::ST_RESET_CK: begin
                if (src_edge) begin
                    nxt_cnt = cnt_ff + 14'h1;
                    if (nxt_cnt == ccs_pkg::RESET_CK_CYCLES) begin
                        nxt_state = ccs_pkg::ST_RUN;
                    end
                end
            end
            ccs_pkg::ST_RUN: begin
                nxt_cnt = '0;
                if (I_SLEEP_REQ) begin
                    nxt_state = ccs_pkg::ST_SLEEP;
                end
            end
            ccs_pkg::ST_SLEEP: begin
                if (wake_evt) begin
                    if (mode_ff == ccs_pkg::SLEEP_IDLE || mode_ff == ccs_pkg::SLEEP_ADC_NOISE) begin
                        nxt_state = ccs_pkg::ST_RUN;
                    end else begin
                        nxt_state = ccs_pkg::ST_WAKE_CK;
                    end
                end
            end
            ccs_pkg::ST_WAKE_CK: begin
                if (src_edge) begin
                    nxt_cnt = cnt_ff + 14'h1;
                    if (nxt_cnt == ccs_pkg::WAKE_CK_CYCLES) begin
                        nxt_state = ccs_pkg::ST_RUN;
                    end
                end
            end
            default: begin
                nxt_state = ccs_pkg::ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_ff <= ccs_pkg::ST_LOAD;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_ff <= ccs_pkg::SLEEP_IDLE;
        end else if (state_ff == ccs_pkg::ST_RUN && I_SLEEP_REQ) begin
            mode_ff <= I_SLEEP_MODE;
        end
    end

    // ------------------------------------------------------------
    // system clock divider
    // ------------------------------------------------------------
    assign div_mask = (prescale_ff >= ccs_pkg::PRESCALE_MAX) ? ccs_pkg::DIV_MASK_MAX :
                      8'((ccs_pkg::DIV_ONE << prescale_ff) - ccs_pkg::DIV_ONE);
    assign run_gate = (state_ff == ccs_pkg::ST_RUN);

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            div_cnt_ff <= '0;
            O_SYS_TICK <= 1'b0;
        end else begin
            if (src_edge) begin
                div_cnt_ff <= div_cnt_ff + 8'h1;
            end
            O_SYS_TICK <= src_edge && ((div_cnt_ff & div_mask) == div_mask);
        end
    end

    // ------------------------------------------------------------
    // clock domain gates
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_RUN          <= 1'b0;
            O_CPU_CLK_EN   <= 1'b0;
            O_FLASH_CLK_EN <= 1'b0;
            O_IO_CLK_EN    <= 1'b0;
            O_ADC_CLK_EN   <= 1'b0;
        end else if (!run_gate && state_ff != ccs_pkg::ST_SLEEP) begin
            O_RUN          <= 1'b0;
            O_CPU_CLK_EN   <= 1'b0;
            O_FLASH_CLK_EN <= 1'b0;
            O_IO_CLK_EN    <= 1'b0;
            O_ADC_CLK_EN   <= 1'b0;
        end else if (state_ff == ccs_pkg::ST_SLEEP) begin
            O_RUN          <= 1'b0;
            O_CPU_CLK_EN   <= 1'b0;
            O_FLASH_CLK_EN <= 1'b0;
            O_IO_CLK_EN    <= (mode_ff == ccs_pkg::SLEEP_IDLE);
            O_ADC_CLK_EN   <= (mode_ff == ccs_pkg::SLEEP_IDLE) ||
                              (mode_ff == ccs_pkg::SLEEP_ADC_NOISE);
        end else if (src_edge) begin
            O_RUN          <= 1'b1;
            O_CPU_CLK_EN   <= 1'b1;
            O_FLASH_CLK_EN <= 1'b1;
            O_IO_CLK_EN    <= 1'b1;
            O_ADC_CLK_EN   <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // oscillator controls and status
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_OSCILLATOR_TRIM <= {ccs_pkg::TRIM_RESERVED_BIT, ccs_pkg::TRIM_RST};
            O_RC_FAST         <= 1'b1;
            O_RC_ENABLE       <= 1'b1;
            O_LOWRATE_ENABLE  <= 1'b0;
            O_PRESCALE_SELECT <= ccs_pkg::PRESCALE_RST_DIV8;
            O_WDT_TICK        <= 1'b0;
            O_EXT_INT_SEEN    <= 1'b0;
        end else begin
            O_OSCILLATOR_TRIM <= {ccs_pkg::TRIM_RESERVED_BIT, trim_ff};
            O_RC_FAST         <= (src_sel_ff == ccs_pkg::SRC_RC_9M6);
            O_RC_ENABLE       <= (src_sel_ff == ccs_pkg::SRC_RC_9M6) ||
                                 (src_sel_ff == ccs_pkg::SRC_RC_4M8);
            O_LOWRATE_ENABLE  <= (src_sel_ff == ccs_pkg::SRC_LOWRATE);
            O_PRESCALE_SELECT <= prescale_ff;
            O_WDT_TICK        <= wdt_edge;
            O_EXT_INT_SEEN    <= sync_out[ccs_pkg::SY_EXT_INT];
        end
    end

endmodule

`default_nettype wire

// >>> core/ccs_pkg.sv
package ccs_pkg;

    // ------------------------------------------------------------
    // fuse encodings (0 = programmed, 1 = unprogrammed)
    // ------------------------------------------------------------
    localparam logic       FUSE_PROGRAMMED  = 1'b0;
    localparam logic [1:0] SRC_EXT_CLOCK    = 2'h0;
    localparam logic [1:0] SRC_RC_4M8       = 2'h1;
    localparam logic [1:0] SRC_RC_9M6       = 2'h2;
    localparam logic [1:0] SRC_LOWRATE      = 2'h3;
    localparam logic [1:0] SUT_14CK         = 2'h0;
    localparam logic [1:0] SUT_14CK_4MS     = 2'h1;
    localparam logic [1:0] SUT_14CK_64MS    = 2'h2;

    // ------------------------------------------------------------
    // start-up timing, in cycles of the named oscillator
    // ------------------------------------------------------------
    localparam int          SHORT_TIMEOUT_MS   = 4;
    localparam int          LONG_TIMEOUT_MS    = 64;
    localparam logic [13:0] WDT_CYCLES_4MS     = 14'h0200;
    localparam int          WDT_CYCLES_64MS    = 8192;
    localparam logic [13:0] RESET_CK_CYCLES    = 14'h000E;
    localparam logic [13:0] WAKE_CK_CYCLES     = 14'h0006;
    localparam logic [1:0]  SYNC_SETTLE_CYCLES = 2'h2;

    // ------------------------------------------------------------
    // prescaler and trim
    // ------------------------------------------------------------
    localparam logic [3:0] PRESCALE_RST_DIV8 = 4'h3;
    localparam logic [3:0] PRESCALE_RST_DIV1 = 4'h0;
    localparam logic [3:0] PRESCALE_MAX      = 4'h8;
    localparam logic [7:0] DIV_MASK_MAX      = 8'hFF;
    localparam logic [7:0] DIV_ONE           = 8'h01;
    localparam logic [6:0] TRIM_RST          = 7'h00;
    localparam logic       TRIM_RESERVED_BIT = 1'b0;

    // ------------------------------------------------------------
    // sleep modes
    // ------------------------------------------------------------
    localparam logic [1:0] SLEEP_IDLE       = 2'h0;
    localparam logic [1:0] SLEEP_ADC_NOISE  = 2'h1;
    localparam logic [1:0] SLEEP_POWER_DOWN = 2'h2;

    // ------------------------------------------------------------
    // synchroniser bit positions
    // ------------------------------------------------------------
    localparam int SYNC_W     = 10;
    localparam int SY_EXT_CLK = 0;
    localparam int SY_RC_CLK  = 1;
    localparam int SY_LR_CLK  = 2;
    localparam int SY_WDT_CLK = 3;
    localparam int SY_EXT_INT = 4;
    localparam int SY_SRC_LO  = 5;
    localparam int SY_SRC_HI  = 6;
    localparam int SY_SUT_LO  = 7;
    localparam int SY_SUT_HI  = 8;
    localparam int SY_DIV8    = 9;

    typedef enum logic [5:0] {
        ST_LOAD      = 6'b000001,
        ST_RESET_WDT = 6'b000010,
        ST_RESET_CK  = 6'b000100,
        ST_RUN       = 6'b001000,
        ST_SLEEP     = 6'b010000,
        ST_WAKE_CK   = 6'b100000
    } ccs_state_t;

endpackage

// >>> core/ccs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ccs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= '0;
            o_sync  <= '0;
        end else begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end

endmodule

`default_nettype wire
